// >>> common/tams_regs.vh
// constants for the touch and auxiliary measurement sequencer
`ifndef TAMS_REGS_VH
`define TAMS_REGS_VH
`define TAMS_CLK_PS 10000
`define TAMS_PRE_TOUCH_PS 2125000
`define TAMS_PRE_AUX_PS 2625000
`define TAMS_SAMPLE_PS 4400000
`define TAMS_CNT_W 24
`define TAMS_CMD_W 4
`define TAMS_CMD_NONE 4'h0
`define TAMS_CMD_XDRV 4'h1
`define TAMS_CMD_YDRV 4'h2
`define TAMS_CMD_ZDRV 4'h3
`define TAMS_CMD_XCONV 4'h4
`define TAMS_CMD_YCONV 4'h5
`define TAMS_CMD_Z1CONV 4'h6
`define TAMS_CMD_Z2CONV 4'h7
`define TAMS_CMD_TSNG 4'h8
`define TAMS_CMD_THIB 4'h9
`define TAMS_CMD_BAT1 4'ha
`define TAMS_CMD_BAT2 4'hb
`define TAMS_CMD_AUXA 4'hc
`define TAMS_CMD_AUXB 4'hd
`define TAMS_DRV_OFF 2'h0
`define TAMS_DRV_X 2'h1
`define TAMS_DRV_Y 2'h2
`define TAMS_DRV_Z 2'h3
`define TAMS_SEL_W 4
`define TAMS_RES_W 16
`define TAMS_AVG_W 4
`endif

// >>> design/tams_sequencer.v
// measurement sequencer for touch panel, temperature, battery and aux
// How it works
// - pen touch pulls pen_touch_irq_n low, in every mode
// - touch conversion: 2.125 us, then per sample bits/fconv plus 4.4 us
// - temperature single mode converts the diode at low bias into its result
// - differential mode converts at 82x bias into the second temperature result
// - battery one divided by four, battery two by two before conversion
// - battery divider connected only while that input is sampled
// - temp/aux/battery: 2.625 us plus reference delay plus per-sample time
// - on-demand reference powers up at temp/aux/battery measurement start, delay included
// - aux inputs measured like battery, undivided, into the shared result_o tagged by result_sel_o
// - result_valid_n driven low when a result is stored
// - results right-justified in 16 bits, upper bits zero
`timescale 1ns/100ps
`include "tams_regs.vh"
module tams_sequencer #(
  parameter BITS = 12,
  parameter CONV_CLK_DIV = 4,
  parameter REF_DELAY_CYC = 100,
  parameter PRE_TOUCH_CYC = (`TAMS_PRE_TOUCH_PS + `TAMS_CLK_PS - 1)
    / `TAMS_CLK_PS,
  parameter PRE_AUX_CYC = (`TAMS_PRE_AUX_PS + `TAMS_CLK_PS - 1)
    / `TAMS_CLK_PS,
  parameter SAMPLE_CYC = (`TAMS_SAMPLE_PS + `TAMS_CLK_PS - 1)
    / `TAMS_CLK_PS
) (
  input wire clk_i,
  input wire srst_i,
  input wire pen_touch_i,
  input wire cmd_valid_i,
  input wire [`TAMS_CMD_W-1:0] cmd_i,
  input wire [`TAMS_AVG_W-1:0] average_count_i,
  input wire ref_on_demand_i,
  input wire [BITS-1:0] adc_data_i,
  input wire result_ack_i,
  output reg pen_touch_irq_n_o,
  output reg busy_o,
  output reg [1:0] panel_drv_o,
  output reg [`TAMS_SEL_W-1:0] adc_sel_o,
  output reg adc_sample_o,
  output reg temp_high_bias_o,
  output reg bat_quarter_div_o,
  output reg bat_half_div_o,
  output reg ref_power_o,
  output reg result_valid_n_o,
  output reg [`TAMS_SEL_W-1:0] result_sel_o,
  output reg [`TAMS_RES_W-1:0] result_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PRE = 3'h1;
  localparam ST_REF = 3'h2;
  localparam ST_SAMP = 3'h3;
  localparam ST_CONV = 3'h4;
  localparam ST_DONE = 3'h5;
  localparam [`TAMS_CNT_W-1:0] CONV_CYC = BITS * CONV_CLK_DIV;
  localparam SW = 3;

  reg [SW-1:0] state_r;
  reg [`TAMS_CNT_W-1:0] cnt_r;
  reg [`TAMS_AVG_W-1:0] avg_left_r;
  reg [`TAMS_SEL_W-1:0] sel_r;
  reg is_touch_r;
  reg [BITS+`TAMS_AVG_W-1:0] acc_r;
  reg [`TAMS_RES_W-1:0] avg_res;
  reg [BITS+`TAMS_AVG_W-1:0] div_q;

  wire cnt_zero = (cnt_r == {`TAMS_CNT_W{1'b0}});
  // only defined codes start a sequence
  wire cmd_legal = (cmd_i <= `TAMS_CMD_AUXB);
  wire take_cmd = cmd_valid_i && (state_r == ST_IDLE);
  wire conv_cmd = take_cmd && cmd_legal && (cmd_i >= `TAMS_CMD_XCONV);
  wire touch_cmd = (cmd_i < `TAMS_CMD_TSNG);
  wire ref_cmd = !touch_cmd && ref_on_demand_i;
  wire last_sample = (avg_left_r ==
    {{(`TAMS_AVG_W-1){1'b0}}, 1'b1});
  wire store_now = (state_r == ST_DONE);
  wire [`TAMS_AVG_W-1:0] avg_n = (average_count_i == {`TAMS_AVG_W{1'b0}}) ?
    {{(`TAMS_AVG_W-1){1'b0}}, 1'b1} : average_count_i;

  always @* begin
    div_q = acc_r / avg_n;
    avg_res = {`TAMS_RES_W{1'b0}};
    avg_res[BITS-1:0] = div_q[BITS-1:0];
  end

  // registered pen touch request
  always @(posedge clk_i) begin
    if (srst_i)
      pen_touch_irq_n_o <= 1'b1;
    else
      pen_touch_irq_n_o <= ~pen_touch_i;
  end

  // store wins over a clearing read in the same cycle
  always @(posedge clk_i) begin
    if (srst_i)
      result_valid_n_o <= 1'b1;
    else if (store_now)
      result_valid_n_o <= 1'b0;
    else if (result_ack_i)
      result_valid_n_o <= 1'b1;
  end

  // panel drivers follow host commands only while idle
  always @(posedge clk_i) begin
    if (srst_i)
      panel_drv_o <= `TAMS_DRV_OFF;
    else if (take_cmd) begin
      case (cmd_i)
        `TAMS_CMD_NONE: panel_drv_o <= `TAMS_DRV_OFF;
        `TAMS_CMD_XDRV: panel_drv_o <= `TAMS_DRV_X;
        `TAMS_CMD_YDRV: panel_drv_o <= `TAMS_DRV_Y;
        `TAMS_CMD_ZDRV: panel_drv_o <= `TAMS_DRV_Z;
        default: panel_drv_o <= panel_drv_o;
      endcase
    end
  end

  // measurement sequence and timing
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= {`TAMS_CNT_W{1'b0}};
      avg_left_r <= {`TAMS_AVG_W{1'b0}};
      sel_r <= `TAMS_CMD_NONE;
      is_touch_r <= 1'b0;
      acc_r <= {(BITS+`TAMS_AVG_W){1'b0}};
      busy_o <= 1'b0;
      adc_sel_o <= `TAMS_CMD_NONE;
      adc_sample_o <= 1'b0;
      temp_high_bias_o <= 1'b0;
      bat_quarter_div_o <= 1'b0;
      bat_half_div_o <= 1'b0;
      ref_power_o <= 1'b0;
      result_sel_o <= `TAMS_CMD_NONE;
      result_o <= {`TAMS_RES_W{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (conv_cmd) begin
            sel_r <= cmd_i;
            adc_sel_o <= cmd_i;
            is_touch_r <= touch_cmd;
            temp_high_bias_o <= (cmd_i == `TAMS_CMD_THIB);
            avg_left_r <= avg_n;
            acc_r <= {(BITS+`TAMS_AVG_W){1'b0}};
            busy_o <= 1'b1;
            state_r <= ST_PRE;
            if (touch_cmd)
              cnt_r <= PRE_TOUCH_CYC[`TAMS_CNT_W-1:0] - 1'b1;
            else
              cnt_r <= PRE_AUX_CYC[`TAMS_CNT_W-1:0] - 1'b1;
            if (ref_cmd)
              ref_power_o <= 1'b1;
          end
        end
        ST_PRE: begin
          if (!cnt_zero)
            cnt_r <= cnt_r - 1'b1;
          else if (!is_touch_r && ref_on_demand_i) begin
            cnt_r <= REF_DELAY_CYC[`TAMS_CNT_W-1:0] - 1'b1;
            state_r <= ST_REF;
          end else begin
            cnt_r <= SAMPLE_CYC[`TAMS_CNT_W-1:0] - 1'b1;
            state_r <= ST_SAMP;
          end
        end
        ST_REF: begin
          if (!cnt_zero)
            cnt_r <= cnt_r - 1'b1;
          else begin
            cnt_r <= SAMPLE_CYC[`TAMS_CNT_W-1:0] - 1'b1;
            state_r <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          adc_sample_o <= !cnt_zero;
          bat_quarter_div_o <= !cnt_zero &&
            (sel_r == `TAMS_CMD_BAT1);
          bat_half_div_o <= !cnt_zero &&
            (sel_r == `TAMS_CMD_BAT2);
          if (!cnt_zero)
            cnt_r <= cnt_r - 1'b1;
          else begin
            cnt_r <= CONV_CYC - 1'b1;
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (!cnt_zero)
            cnt_r <= cnt_r - 1'b1;
          else begin
            acc_r <= acc_r + {{`TAMS_AVG_W{1'b0}}, adc_data_i};
            avg_left_r <= avg_left_r - 1'b1;
            if (last_sample)
              state_r <= ST_DONE;
            else begin
              cnt_r <= SAMPLE_CYC[`TAMS_CNT_W-1:0] - 1'b1;
              state_r <= ST_SAMP;
            end
          end
        end
        ST_DONE: begin
          result_o <= avg_res;
          result_sel_o <= sel_r;
          busy_o <= 1'b0;
          ref_power_o <= 1'b0;
          temp_high_bias_o <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> verif/tams_adc_model.sv
// converter stand-in feeding sample codes per channel
`timescale 1ns/100ps
module tams_adc_model (
  input wire busy_i,
  input wire [3:0] sel_i,
  input wire [11:0] base_i,
  output wire [11:0] adc_data_o
);
  // idle shows inverted code, never a stale value
  assign adc_data_o = busy_i ? base_i ^ {8'h00, sel_i} : ~base_i;
endmodule

// >>> verif/tams_sequencer_asserts.sv
// port checker for the measurement sequencer
`timescale 1ns/100ps
`include "tams_regs.vh"
module tams_sequencer_asserts #(parameter BITS = 12) (
  input wire clk_i, input wire srst_i, input wire pen_touch_i,
  input wire cmd_valid_i, input wire [3:0] cmd_i,
  input wire ref_on_demand_i, input wire result_ack_i,
  input wire pen_touch_irq_n_o, input wire busy_o,
  input wire [3:0] adc_sel_o, input wire adc_sample_o,
  input wire temp_high_bias_o, input wire bat_quarter_div_o,
  input wire bat_half_div_o, input wire ref_power_o,
  input wire result_valid_n_o, input wire [15:0] result_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_conv;
    cmd_valid_i && !busy_o && cmd_i >= `TAMS_CMD_XCONV;
  endsequence
  AST_IRQ: assert property (1 |=> pen_touch_irq_n_o == !$past(pen_touch_i))
    else $error("pen irq wrong");
  AST_RJUST: assert property ((result_o >> BITS) == 16'h0000)
    else $error("result upper bits set");
  AST_QDIV: assert property (bat_quarter_div_o |->
    adc_sample_o && adc_sel_o == `TAMS_CMD_BAT1) else $error("quarter div");
  AST_HDIV: assert property (bat_half_div_o |->
    adc_sample_o && adc_sel_o == `TAMS_CMD_BAT2) else $error("half div");
  AST_BIAS: assert property (temp_high_bias_o |->
    busy_o && adc_sel_o == `TAMS_CMD_THIB) else $error("bias wrong");
  AST_HOLD: assert property (!result_valid_n_o && !result_ack_i |=>
    !result_valid_n_o) else $error("valid dropped");
  AST_DONE: assert property ($fell(result_valid_n_o) |->
    !busy_o && $past(busy_o)) else $error("valid off sequence");
  AST_MIN: assert property (s_conv |=> (!$fell(result_valid_n_o))[*8])
    else $error("result too early");
  AST_REF: assert property (s_conv ##0 (ref_on_demand_i &&
    cmd_i >= `TAMS_CMD_TSNG) |-> ##[1:4] ref_power_o) else $error("no ref");
  AST_SEL: assert property (s_conv |=> busy_o &&
    adc_sel_o == $past(cmd_i)) else $error("channel wrong");
endmodule
bind tams_sequencer tams_sequencer_asserts #(.BITS(BITS)) asserts_inst (.*);

// >>> verif/tb.sv
// self-checking bench for the measurement sequencer
`timescale 1ns/100ps
module tb;
  reg clk_i = 0, srst_i = 1, pen_touch_i = 0, cmd_valid_i = 0;
  reg [3:0] cmd_i = 0, average_count_i = 0;
  reg ref_on_demand_i = 0, result_ack_i = 0;
  reg [11:0] base = 0;
  wire [11:0] adc_data_i;
  wire pen_touch_irq_n_o, busy_o, adc_sample_o, temp_high_bias_o;
  wire bat_quarter_div_o, bat_half_div_o, ref_power_o, result_valid_n_o;
  wire [1:0] panel_drv_o;
  wire [3:0] adc_sel_o, result_sel_o;
  wire [15:0] result_o;
  integer mismatches = 0, checks = 0, seed = 32'hf6e5, c, n, t, lo;
  initial forever #5 clk_i = ~clk_i;
  tams_sequencer #(.CONV_CLK_DIV(1), .REF_DELAY_CYC(4), .PRE_TOUCH_CYC(3),
    .PRE_AUX_CYC(5), .SAMPLE_CYC(4)) tams_sequencer_inst (.*);
  tams_adc_model tams_adc_model_inst (.busy_i(busy_o), .sel_i(adc_sel_o),
    .base_i(base), .adc_data_o(adc_data_i));
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task send(input [3:0] code);
    begin
      @(posedge clk_i);
      #1 cmd_i = code;
      cmd_valid_i = 1;
      @(posedge clk_i);
      #1 cmd_valid_i = 0;
    end
  endtask
  task conv(input [3:0] code);
    begin
      average_count_i = $random(seed) & 3;
      base = $random(seed);
      n = (average_count_i == 0) ? 1 : average_count_i;
      lo = (code < 8 ? 3 : 5 + (ref_on_demand_i ? 4 : 0)) + n * 16;
      send(code);
      t = 1;
      while (result_valid_n_o !== 1'b0 && t < 500) begin
        @(posedge clk_i);
        #1 t = t + 1;
      end
      check(t >= lo && t <= lo + 4, 1, "time");
      check(result_o, {4'h0, base ^ {8'h00, code}}, "result");
      check(result_sel_o, code, "sel");
      result_ack_i = 1;
      @(posedge clk_i);
      #1 result_ack_i = 0;
      @(posedge clk_i);
      #1 check(result_valid_n_o, 1, "ack");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    #1 srst_i = 0;
    pen_touch_i = 1;
    repeat (2) @(posedge clk_i);
    #1 check(pen_touch_irq_n_o, 0, "irq");
    for (c = 4; c < 14; c = c + 1) begin
      ref_on_demand_i = $random(seed);
      if (c < 8) begin
        send(c < 6 ? c - 3 : 3);
        check(panel_drv_o, c < 6 ? c - 3 : 3, "drv");
        repeat (4) @(posedge clk_i);
        #1 ;
      end
      conv(c);
    end
    send(0);
    check(panel_drv_o, 0, "drv");
    pen_touch_i = 0;
    repeat (2) @(posedge clk_i);
    #1 check(pen_touch_irq_n_o, 1, "irq");
    finish_test;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule
